// ### src/ueb_consts.vh
`ifndef UEB_CONSTS_VH
`define UEB_CONSTS_VH

// ==========================================================================
// External data space regions (byte addresses on paddr[15:0])
`define UEB_SCRATCH_BASE   16'hE000
`define UEB_SCRATCH_LAST   16'hE1FF
`define UEB_WAVE_BASE      16'hE400
`define UEB_WAVE_LAST      16'hE47F
`define UEB_REGWIN_BASE    16'hE500
`define UEB_REGWIN_LAST    16'hE6FF
`define UEB_SMALL_BASE     16'hE740
`define UEB_SMALL_LAST     16'hE7FF
`define UEB_LARGE_BASE     16'hF000
`define UEB_LARGE_LAST     16'hFFFF

// ==========================================================================
// Registers inside the control window
`define UEB_IFCFG_ADDR     16'hE600
`define UEB_EPCFG_ADDR     16'hE604
`define UEB_SPEED_ADDR     16'hE608
`define UEB_CTLOUT_ADDR    16'hE60C
`define UEB_IRQSTAT_ADDR   16'hE610
`define UEB_IRQMASK_ADDR   16'hE614
`define UEB_FLAGS_ADDR     16'hE618
`define UEB_CNT_PAGE       12'hE62
`define UEB_SETUP_LO_ADDR  16'hE6B8
`define UEB_SETUP_HI_ADDR  16'hE6BC

// ==========================================================================
// Interface configuration fields and modes
`define UEB_IFCFG_INV      4
`define UEB_IFCFG_OE       5
`define UEB_IFCFG_FAST     6
`define UEB_IFCFG_INT      7
`define UEB_MODE_PORT      2'h0
`define UEB_MODE_WAVE      2'h2
`define UEB_MODE_SLAVE     2'h3

// ==========================================================================
// Reset values and layout count
`define UEB_IFCFG_RST      8'h00
`define UEB_EPCFG_RST      4'h0
`define UEB_CTLOUT_RST     2'h3
`define UEB_CFG_COUNT      4'hC

// ==========================================================================
// Buffer sizes
`define UEB_HS_PKT         13'h0200
`define UEB_FS_PKT         13'h0040
`define UEB_FS_OFF_LIMIT   9'h040
`define UEB_SMALL_IDX_OFS  6'h10

// ==========================================================================
// Interrupt status bits
`define UEB_IRQ_W          4
`define UEB_IRQ_SETUP      0
`define UEB_IRQ_FULL       1
`define UEB_IRQ_EMPTY      2
`define UEB_IRQ_BADCFG     3

// ==========================================================================
// Clock rates in MHz
`define UEB_PCLK_MHZ       250
`define UEB_ICLK_SLOW_MHZ  30
`define UEB_ICLK_FAST_MHZ  48

`endif

// ### src/ueb_mem.v
// ==========================================================================
// Word memory with byte lanes and registered read data
module ueb_mem #(
   parameter AW    = 7,
   parameter DEPTH = 128
) (
   // Clock
   input  wire          clk,
   // Access
   input  wire          re,
   input  wire          we,
   input  wire [3:0]    strb,
   input  wire [AW-1:0] addr,
   input  wire [31:0]   wdata,
   output wire [31:0]   rdata
);

   genvar lane;
   generate
      for (lane = 0; lane < 4; lane = lane + 1)
      begin : g_lane
         reg [7:0] mem [0:DEPTH-1];
         reg [7:0] q;
         always @(posedge clk)
         begin
            if (we && strb[lane])
               mem[addr] <= wdata[lane*8 +: 8];
            if (re)
               q <= mem[addr];
         end
         assign rdata[lane*8 +: 8] = q;
      end
   endgenerate

endmodule // ueb_mem

// ### src/ueb_interface_clock.v
`include "ueb_consts.vh"

// ==========================================================================
// Interface clock source, pin sampling and reference edge
module ueb_iclk (
   // Clock and reset
   input  wire pclk,
   input  wire presetn,
   // Configuration
   input  wire internal_src,
   input  wire rate_fast,
   input  wire invert,
   input  wire out_en,
   // Pin
   input  wire interface_clock_in,
   output reg  interface_clock_out,
   output reg  interface_clock_oe,
   // Reference edge pulse
   output reg  ref_rise
);

   localparam [8:0] MOD       = `UEB_PCLK_MHZ;
   localparam [8:0] STEP_SLOW = 2 * `UEB_ICLK_SLOW_MHZ;
   localparam [8:0] STEP_FAST = 2 * `UEB_ICLK_FAST_MHZ;

   reg  [8:0] acc;
   reg        gen;
   reg        pin_s1;
   reg        pin_s2;
   reg        ref_prev;
   wire [8:0] sum      = acc + (rate_fast ? STEP_FAST : STEP_SLOW);
   wire       wrap     = (sum >= MOD);
   wire       next_gen = wrap ? ~gen : gen;
   wire       ref_now  = (internal_src ? next_gen : pin_s2) ^ invert;

   // Fractional divider: toggles at twice the chosen rate
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         acc                 <= 9'h000;
         gen                 <= 1'b0;
         pin_s1              <= 1'b0;
         pin_s2              <= 1'b0;
         ref_prev            <= 1'b0;
         ref_rise            <= 1'b0;
         interface_clock_out <= 1'b0;
         interface_clock_oe  <= 1'b0;
      end
      else
      begin
         acc                 <= wrap ? (sum - MOD) : sum;
         gen                 <= next_gen;
         pin_s1              <= interface_clock_in;
         pin_s2              <= pin_s1;
         ref_prev            <= ref_now;
         ref_rise            <= ref_now & ~ref_prev;
         interface_clock_out <= next_gen ^ invert;
         interface_clock_oe  <= internal_src & out_en;
      end
   end

endmodule // ueb_iclk

// ### src/ueb_top.v
// Behaviour
// - Large endpoint buffers at F000 to FFFF
// - Waveform memory, 128 bytes from E400
// - Scratch RAM, 512 bytes from E000
// - Register window decoded from E500 to E6FF
// - Endpoint zero shares one 64-byte buffer
// - Endpoint one has separate 64-byte buffers
// - Endpoints two to eight use 512-byte buffers
// - Setup packet kept at E6B8 to E6BF
// - Endpoints zero and one never change
// - Exactly one of twelve buffer layouts
// - Full speed uses first 64 bytes only
// - Idle full-speed bytes stay unavailable
// - Two-bit mode field, port mode default
// - Interface clock times flags and controls
// - Internal source drives 30 or 48 MHz
// - Configuration bit four inverts interface clock
// - Flag two is control or full
// - Flag three is control or empty
//
// The APB register port and the placing of the registers were chosen for this implementation.
`include "ueb_consts.vh"

module ueb_top (
   // APB clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // Interface clock pin
   input  wire        interface_clock_in,
   output wire        interface_clock_out,
   output wire        interface_clock_oe,
   // FIFO master side
   input  wire [1:0]  fifo_select_pins,
   output reg         fifo_status_flag_two,
   output reg         fifo_status_flag_three,
   // Interrupt
   output wire        irq
);

   // =======================================================================
   // Read source codes
   localparam [2:0] SRC_REG   = 3'h0;
   localparam [2:0] SRC_SCR   = 3'h1;
   localparam [2:0] SRC_WAVE  = 3'h2;
   localparam [2:0] SRC_SMALL = 3'h3;
   localparam [2:0] SRC_LARGE = 3'h4;
   localparam [2:0] SRC_ZERO  = 3'h5;

   // =======================================================================
   // Buffer layouts: buffer counts {ep8, ep6, ep4, ep2}
   function [15:0] layout;
      input [3:0] sel;
      begin
         case (sel)
            4'h0:    layout = 16'h2222;
            4'h1:    layout = 16'h0422;
            4'h2:    layout = 16'h2204;
            4'h3:    layout = 16'h0303;
            4'h4:    layout = 16'h0404;
            4'h5:    layout = 16'h2402;
            4'h6:    layout = 16'h0224;
            4'h7:    layout = 16'h0323;
            4'h8:    layout = 16'h0402;
            4'h9:    layout = 16'h2203;
            4'hA:    layout = 16'h0302;
            4'hB:    layout = 16'h2024;
            default: layout = 16'h2222;
         endcase
      end
   endfunction

   // =======================================================================
   // Address decode
   wire [15:0] a         = paddr[15:0];
   wire        low_space = (paddr[31:16] == 16'h0000);
   wire        setup_ph  = psel & ~penable;
   wire        access_ph = psel & penable;
   wire        wr_acc    = access_ph & pwrite;

   wire hit_scr   = low_space && a >= `UEB_SCRATCH_BASE && a <= `UEB_SCRATCH_LAST;
   wire hit_wave  = low_space && a >= `UEB_WAVE_BASE && a <= `UEB_WAVE_LAST;
   wire hit_win   = low_space && a >= `UEB_REGWIN_BASE && a <= `UEB_REGWIN_LAST;
   wire hit_small = low_space && a >= `UEB_SMALL_BASE && a <= `UEB_SMALL_LAST;
   wire hit_large = low_space && a >= `UEB_LARGE_BASE;
   wire hit_none  = ~(hit_scr | hit_wave | hit_win | hit_small | hit_large);

   wire hit_ifcfg = hit_win && a[15:2] == `UEB_IFCFG_ADDR >> 2;
   wire hit_epcfg = hit_win && a[15:2] == `UEB_EPCFG_ADDR >> 2;
   wire hit_speed = hit_win && a[15:2] == `UEB_SPEED_ADDR >> 2;
   wire hit_ctl   = hit_win && a[15:2] == `UEB_CTLOUT_ADDR >> 2;
   wire hit_stat  = hit_win && a[15:2] == `UEB_IRQSTAT_ADDR >> 2;
   wire hit_mask  = hit_win && a[15:2] == `UEB_IRQMASK_ADDR >> 2;
   wire hit_flags = hit_win && a[15:2] == `UEB_FLAGS_ADDR >> 2;
   wire hit_cnt   = hit_win && a[15:4] == `UEB_CNT_PAGE;
   wire hit_sulo  = hit_win && a[15:2] == `UEB_SETUP_LO_ADDR >> 2;
   wire hit_suhi  = hit_win && a[15:2] == `UEB_SETUP_HI_ADDR >> 2;

   // =======================================================================
   // Control registers
   reg  [7:0]  ifcfg;
   reg  [3:0]  epcfg;
   reg         full_speed;
   reg  [1:0]  ctl_out;
   reg  [3:0]  irq_stat;
   reg  [3:0]  irq_mask;
   reg  [47:0] fifo_cnt;
   reg  [31:0] setup_lo;
   reg  [31:0] setup_hi;

   wire [1:0]  mode      = ifcfg[1:0];
   wire        bad_cfg   = hit_epcfg & pwrite & (pwdata[3:0] >= `UEB_CFG_COUNT);
   wire        large_off = hit_large & full_speed & (a[8:0] >= `UEB_FS_OFF_LIMIT);
   wire        large_ok  = hit_large & ~large_off;

   // Zero-wait slave; unmapped addresses and bad layouts answer with an error
   assign pready  = 1'b1;
   assign pslverr = access_ph & (hit_none | bad_cfg);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ifcfg      <= `UEB_IFCFG_RST;
         epcfg      <= `UEB_EPCFG_RST;
         full_speed <= 1'b0;
         ctl_out    <= `UEB_CTLOUT_RST;
         irq_mask   <= {`UEB_IRQ_W{1'b0}};
         fifo_cnt   <= 48'h000000000000;
      end
      else if (wr_acc && pstrb[0])
      begin
         if (hit_ifcfg)
            ifcfg <= pwdata[7:0];
         if (hit_epcfg && !bad_cfg)
            epcfg <= pwdata[3:0];
         if (hit_speed)
            full_speed <= pwdata[0];
         if (hit_ctl)
            ctl_out <= pwdata[1:0];
         if (hit_mask)
            irq_mask <= pwdata[3:0];
         if (hit_cnt)
            fifo_cnt[a[3:2]*12 +: 12] <= pwdata[11:0];
      end
   end

   // Setup packet words with byte lanes
   integer ln;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         setup_lo <= 32'h00000000;
         setup_hi <= 32'h00000000;
      end
      else if (wr_acc)
      begin
         for (ln = 0; ln < 4; ln = ln + 1)
         begin
            if (pstrb[ln] && hit_sulo)
               setup_lo[ln*8 +: 8] <= pwdata[ln*8 +: 8];
            if (pstrb[ln] && hit_suhi)
               setup_hi[ln*8 +: 8] <= pwdata[ln*8 +: 8];
         end
      end
   end

   // =======================================================================
   // FIFO capacity and flags per large endpoint
   wire [15:0] nbuf = layout(epcfg);
   wire [12:0] pkt  = full_speed ? `UEB_FS_PKT : `UEB_HS_PKT;
   wire [3:0]  fifo_full;
   wire [3:0]  fifo_empty;

   genvar f;
   generate
      for (f = 0; f < 4; f = f + 1)
      begin : g_fifo
         wire [12:0] cap = pkt * {9'h000, nbuf[f*4 +: 4]};
         wire [12:0] cnt = {1'b0, fifo_cnt[f*12 +: 12]};
         assign fifo_full[f]  = (cnt >= cap);
         assign fifo_empty[f] = (cnt == 13'h0000);
      end
   endgenerate

   // =======================================================================
   // Interrupt status, write one to clear, set wins
   reg  [3:0] full_prev;
   reg  [3:0] empty_prev;
   wire [3:0] ev;
   wire [3:0] clr = (wr_acc && pstrb[0] && hit_stat) ? pwdata[3:0] : 4'h0;

   assign ev[`UEB_IRQ_SETUP]  = wr_acc & hit_suhi;
   assign ev[`UEB_IRQ_FULL]   = |(fifo_full & ~full_prev);
   assign ev[`UEB_IRQ_EMPTY]  = |(fifo_empty & ~empty_prev);
   assign ev[`UEB_IRQ_BADCFG] = wr_acc & bad_cfg;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_stat   <= {`UEB_IRQ_W{1'b0}};
         full_prev  <= 4'h0;
         empty_prev <= 4'hF;
      end
      else
      begin
         irq_stat   <= (irq_stat & ~clr) | ev;
         full_prev  <= fifo_full;
         empty_prev <= fifo_empty;
      end
   end

   assign irq = |(irq_stat & irq_mask);

   // =======================================================================
   // Memories
   wire [31:0] scr_rdata;
   wire [31:0] wave_rdata;
   wire [31:0] small_rdata;
   wire [31:0] large_rdata;
   wire        rd_setup = setup_ph & ~pwrite;
   wire [5:0]  small_idx = a[7:2] - `UEB_SMALL_IDX_OFS;

   ueb_mem #(.AW(7), .DEPTH(128)) u_scratch (
      .clk   (pclk),
      .re    (rd_setup & hit_scr),
      .we    (wr_acc & hit_scr),
      .strb  (pstrb),
      .addr  (a[8:2]),
      .wdata (pwdata),
      .rdata (scr_rdata)
   );

   ueb_mem #(.AW(5), .DEPTH(32)) u_wave (
      .clk   (pclk),
      .re    (rd_setup & hit_wave),
      .we    (wr_acc & hit_wave),
      .strb  (pstrb),
      .addr  (a[6:2]),
      .wdata (pwdata),
      .rdata (wave_rdata)
   );

   ueb_mem #(.AW(6), .DEPTH(48)) u_small (
      .clk   (pclk),
      .re    (rd_setup & hit_small),
      .we    (wr_acc & hit_small),
      .strb  (pstrb),
      .addr  (small_idx),
      .wdata (pwdata),
      .rdata (small_rdata)
   );

   ueb_mem #(.AW(10), .DEPTH(1024)) u_large (
      .clk   (pclk),
      .re    (rd_setup & large_ok),
      .we    (wr_acc & large_ok),
      .strb  (pstrb),
      .addr  (a[11:2]),
      .wdata (pwdata),
      .rdata (large_rdata)
   );

   // =======================================================================
   // Read path: register value captured in the setup phase
   reg  [2:0]  rd_src;
   reg  [31:0] reg_rdata;
   reg  [31:0] next_reg_rdata;

   always @*
   begin
      next_reg_rdata = 32'h00000000;
      if (hit_ifcfg)
         next_reg_rdata = {24'h000000, ifcfg};
      else if (hit_epcfg)
         next_reg_rdata = {28'h0000000, epcfg};
      else if (hit_speed)
         next_reg_rdata = {31'h00000000, full_speed};
      else if (hit_ctl)
         next_reg_rdata = {30'h00000000, ctl_out};
      else if (hit_stat)
         next_reg_rdata = {28'h0000000, irq_stat};
      else if (hit_mask)
         next_reg_rdata = {28'h0000000, irq_mask};
      else if (hit_flags)
         next_reg_rdata = {24'h000000, fifo_empty, fifo_full};
      else if (hit_cnt)
         next_reg_rdata = {20'h00000, fifo_cnt[a[3:2]*12 +: 12]};
      else if (hit_sulo)
         next_reg_rdata = setup_lo;
      else if (hit_suhi)
         next_reg_rdata = setup_hi;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rd_src    <= SRC_ZERO;
         reg_rdata <= 32'h00000000;
      end
      else if (setup_ph)
      begin
         reg_rdata <= next_reg_rdata;
         if (hit_scr)
            rd_src <= SRC_SCR;
         else if (hit_wave)
            rd_src <= SRC_WAVE;
         else if (hit_small)
            rd_src <= SRC_SMALL;
         else if (large_ok)
            rd_src <= SRC_LARGE;
         else if (hit_win)
            rd_src <= SRC_REG;
         else
            rd_src <= SRC_ZERO;
      end
   end

   always @*
   begin
      case (rd_src)
         SRC_REG:   prdata = reg_rdata;
         SRC_SCR:   prdata = scr_rdata;
         SRC_WAVE:  prdata = wave_rdata;
         SRC_SMALL: prdata = small_rdata;
         SRC_LARGE: prdata = large_rdata;
         default:   prdata = 32'h00000000;
      endcase
   end

   // =======================================================================
   // Interface clock and flag pins
   wire ref_rise;
   reg  [1:0] sel_s1;
   reg  [1:0] sel_s2;

   ueb_iclk u_iclk (
      .pclk                (pclk),
      .presetn             (presetn),
      .internal_src        (ifcfg[`UEB_IFCFG_INT]),
      .rate_fast           (ifcfg[`UEB_IFCFG_FAST]),
      .invert              (ifcfg[`UEB_IFCFG_INV]),
      .out_en              (ifcfg[`UEB_IFCFG_OE]),
      .interface_clock_in  (interface_clock_in),
      .interface_clock_out (interface_clock_out),
      .interface_clock_oe  (interface_clock_oe),
      .ref_rise            (ref_rise)
   );

   // Flags change only on the interface clock reference edge
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sel_s1                 <= 2'h0;
         sel_s2                 <= 2'h0;
         fifo_status_flag_two   <= 1'b1;
         fifo_status_flag_three <= 1'b1;
      end
      else
      begin
         sel_s1 <= fifo_select_pins;
         sel_s2 <= sel_s1;
         if (ref_rise)
         begin
            if (mode == `UEB_MODE_SLAVE)
            begin
               fifo_status_flag_two   <= fifo_full[sel_s2];
               fifo_status_flag_three <= fifo_empty[sel_s2];
            end
            else
            begin
               fifo_status_flag_two   <= ctl_out[0];
               fifo_status_flag_three <= ctl_out[1];
            end
         end
      end
   end

endmodule // ueb_top

// ### verif/ueb_properties.sv
// ==========================================================================
// Port checker
module ueb_properties (
   // Clock and reset
   input wire        pclk,
   input wire        presetn,
   // APB
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [31:0] paddr,
   input wire        pready,
   input wire        pslverr,
   // Pins
   input wire        interface_clock_oe,
   input wire        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   wire        acc = psel && penable;
   wire [15:0] a   = paddr[15:0];
   wire        lo  = acc && (paddr[31:16] == 16'h0000);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rdy; acc |-> pready; endproperty
   a_rdy: assert property (p_rdy)
      else $error("no ready in access");
   property p_hi; acc && !lo |-> pslverr; endproperty
   a_hi: assert property (p_hi)
      else $error("high address accepted");
   property p_resv;
      lo && (a >= 16'hE200 && a < 16'hE400 || a >= 16'hE480 && a < 16'hE500
      || a >= 16'hE700 && a < 16'hE740 || a < 16'hE000) |-> pslverr;
   endproperty
   a_resv: assert property (p_resv)
      else $error("reserved space accepted");
   property p_gap; lo && a >= 16'hE800 && a < 16'hF000 |-> pslverr; endproperty
   a_gap: assert property (p_gap)
      else $error("gap below large buffers accepted");
   property p_large; lo && a >= 16'hF000 |-> !pslverr; endproperty
   a_large: assert property (p_large)
      else $error("large buffer refused");
   property p_mem;
      lo && (a >= 16'hE000 && a < 16'hE200 || a >= 16'hE400 && a < 16'hE480) |-> !pslverr;
   endproperty
   a_mem: assert property (p_mem)
      else $error("memory refused");
   property p_win; lo && !pwrite && a >= 16'hE500 && a < 16'hE700 |-> !pslverr; endproperty
   a_win: assert property (p_win)
      else $error("window read refused");
   property p_rst; !$past(presetn) |-> !irq && !interface_clock_oe; endproperty
   a_rst: assert property (p_rst)
      else $error("outputs active after reset");
endmodule // ueb_properties

// ### verif/ueb_master.sv
// ==========================================================================
// External FIFO master: link clock and select pins
module ueb_master (
   // Bench control
   input wire       run,
   input wire [1:0] want_sel,
   // Pins
   output reg       link_clk,
   output reg [1:0] fifo_select_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      link_clk = 1'b0;
      fifo_select_pins = 2'h0;
      forever
      begin
         #62.5;
         // Clock stands low between bursts
         if (run || link_clk)
            link_clk = !link_clk;
         if (!link_clk)
            fifo_select_pins = want_sel;
      end
   end
endmodule // ueb_master

// ### verif/tb.sv
`include "ueb_consts.vh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   reg         pclk, presetn, psel, penable, pwrite, run, err;
   reg  [31:0] paddr, pwdata, rd, v;
   reg  [3:0]  pstrb;
   reg  [1:0]  want;
   reg  [15:0] lfsr;
   reg  [31:0] mv [0:10];
   wire [31:0] prdata;
   wire        pready, pslverr, ck_out, ck_oe, fl2, fl3, irq, lclk;
   wire [1:0]  sel;
   wire        pin = ck_oe ? ck_out : lclk;
   integer     mismatches, checked, i, n;
   ueb_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .interface_clock_in(pin),
      .interface_clock_out(ck_out), .interface_clock_oe(ck_oe), .fifo_select_pins(sel),
      .fifo_status_flag_two(fl2), .fifo_status_flag_three(fl3), .irq(irq));
   ueb_master u_master (.run(run), .want_sel(want), .link_clk(lclk),
      .fifo_select_pins(sel));
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // ========================================================================
   // Helpers
   function [15:0] nxt(input [15:0] s);
      nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function [31:0] tbl(input integer k);
      case (k)
         0: tbl = `UEB_SCRATCH_BASE;
         1: tbl = 32'hE1FC;
         2: tbl = `UEB_WAVE_BASE;
         3: tbl = 32'hE47C;
         4: tbl = `UEB_SETUP_LO_ADDR;
         5: tbl = `UEB_SETUP_HI_ADDR;
         6: tbl = `UEB_LARGE_BASE;
         7: tbl = 32'hFFFC;
         8: tbl = `UEB_SMALL_BASE;
         9: tbl = 32'hE780;
         10: tbl = 32'hE7C0;
         11: tbl = 32'hE200;
         12: tbl = 32'hE480;
         13: tbl = 32'hE700;
         14: tbl = 32'hEFFC;
         default: tbl = 32'h0001E000;
      endcase
   endfunction
   task test_done;
      begin
         if (mismatches == 0 && checked > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp)
         begin
            mismatches = mismatches + 1;
            $display("BAD %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task apb(input w, input [31:0] a, input [31:0] d);
      integer k;
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         k = 0;
         while (pready !== 1'b1)
         begin
            if (k == 50)
            begin
               chk(0, 1);
               test_done;
            end
            k = k + 1;
            @(posedge pclk);
         end
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task rdc(input [31:0] a, input [31:0] exp, input e);
      begin
         apb(1'b0, a, 32'h00000000);
         chk(rd, exp);
         chk(err, e);
      end
   endtask
   task wflag(input [1:0] e);
      integer k;
      begin
         k = 0;
         while ({fl3, fl2} !== e && k < 400)
         begin
            @(posedge pclk);
            k = k + 1;
         end
         chk({fl3, fl2}, e);
         if ({fl3, fl2} !== e)
            test_done;
      end
   endtask
   task rises(input integer exp);
      reg p;
      begin
         repeat (20) @(posedge pclk);
         n = 0;
         p = pin;
         repeat (1000)
         begin
            @(posedge pclk);
            n = n + (pin && !p);
            p = pin;
         end
         chk(n >= exp - 2 && n <= exp + 2, 1);
      end
   endtask
   // ========================================================================
   // Main sequence
   initial
   begin
      {presetn, psel, penable, pwrite, run, want, paddr, pwdata} = 0;
      pstrb = 4'hF;
      lfsr = 16'hAE64;
      mismatches = 0;
      checked = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(`UEB_IFCFG_ADDR, 0, 0);
      rdc(`UEB_CTLOUT_ADDR, 3, 0);
      chk({fl3, fl2}, 3);
      for (i = 0; i < 16; i = i + 1)
      begin
         lfsr = nxt(lfsr);
         v = {lfsr, nxt(lfsr)};
         if (i < 11)
            mv[i] = v;
         apb(1'b1, tbl(i), v);
         chk(err, i > 10);
      end
      for (i = 0; i < 16; i = i + 1)
         rdc(tbl(i), i > 10 ? 0 : mv[i], i > 10);
      rdc(32'hE500, 0, 0);
      for (i = 0; i < 12; i = i + 1)
      begin
         apb(1'b1, `UEB_EPCFG_ADDR, i);
         rdc(`UEB_EPCFG_ADDR, i, 0);
      end
      apb(1'b1, `UEB_IRQMASK_ADDR, 0);
      apb(1'b1, `UEB_IRQSTAT_ADDR, 32'hF);
      apb(1'b1, `UEB_EPCFG_ADDR, 12);
      chk(err, 1);
      chk(irq, 0);
      rdc(`UEB_EPCFG_ADDR, 11, 0);
      apb(1'b0, `UEB_IRQSTAT_ADDR, 0);
      chk(rd[3], 1);
      apb(1'b1, `UEB_IRQMASK_ADDR, 8);
      chk(irq, 1);
      apb(1'b1, `UEB_IRQSTAT_ADDR, 8);
      chk(irq, 0);
      // Slave and port mode FIFO flags from the link clock
      run <= 1'b1;
      apb(1'b1, `UEB_EPCFG_ADDR, 0);
      apb(1'b1, `UEB_IFCFG_ADDR, `UEB_MODE_SLAVE);
      wflag(2'b10);
      apb(1'b1, {`UEB_CNT_PAGE, 4'h0}, 32'h400);
      wflag(2'b01);
      lfsr = nxt(lfsr);
      apb(1'b1, {`UEB_CNT_PAGE, 4'h0}, (lfsr & 32'h3FF) | 1);
      wflag(2'b00);
      apb(1'b1, `UEB_SPEED_ADDR, 1);
      apb(1'b1, {`UEB_CNT_PAGE, 4'h0}, 32'h80);
      wflag(2'b01);
      apb(1'b1, `UEB_LARGE_BASE + 32'h40, mv[0]);
      rdc(`UEB_LARGE_BASE + 32'h40, 0, 0);
      rdc(`UEB_LARGE_BASE, mv[6], 0);
      apb(1'b1, `UEB_EPCFG_ADDR, 1);
      want <= 2'h3;
      wflag(2'b11);
      apb(1'b1, `UEB_IFCFG_ADDR, `UEB_MODE_PORT);
      apb(1'b1, `UEB_CTLOUT_ADDR, 1);
      wflag(2'b01);
      apb(1'b1, `UEB_CTLOUT_ADDR, 2);
      wflag(2'b10);
      // Internal clock source
      run <= 1'b0;
      apb(1'b1, `UEB_IFCFG_ADDR, 32'hA0);
      @(posedge pclk);
      chk(ck_oe, 1);
      rises(120);
      apb(1'b1, `UEB_IFCFG_ADDR, 32'hE0);
      rises(192);
      apb(1'b1, `UEB_IFCFG_ADDR, 32'hF0);
      rises(192);
      apb(1'b1, `UEB_IFCFG_ADDR, 32'hC0);
      @(posedge pclk);
      chk(ck_oe, 0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(`UEB_IFCFG_ADDR, 0, 0);
      test_done;
   end
endmodule // tb

bind ueb_top ueb_properties u_prop (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .interface_clock_oe(interface_clock_oe), .irq(irq));
